/* iodsc_pkg.sv */
// Package and pin synchroniser for the I/O channel device subcontroller
`default_nettype none

package iodsc_pkg;
   // Register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_STATE = 4'h8;
   // Control register fields and reset values
   localparam int CTRL_FORCE_OFF_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // State register field positions
   localparam int ST_ONLINE_BIT = 0;
   localparam int ST_MATCH_BIT = 1;
   localparam int ST_ACTIVE_BIT = 2;
   localparam int ST_WINDOW_BIT = 3;
   localparam int ST_STATDRV_BIT = 4;
   localparam int ST_ADDRDRV_BIT = 5;
   localparam int ST_SWADDR_LSB = 8;
   // Timing: least time status stays on the data lines
   localparam int CLK_PERIOD_NS = 50;
   localparam int STAT_HOLD_NS = 150;
   localparam logic [3:0] STAT_HOLD_CYC =
      4'((STAT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Channel inputs from the host side, all asynchronous pins
   typedef struct packed {
      logic [7:0] addr;
      logic query;
      logic ack;
      logic svc;
      logic prio_in;
      logic xfer_end;
   } iodsc_ch_in_t;

   // Switch and power inputs, also asynchronous
   typedef struct packed {
      logic offline;
      logic pwr_ok;
      logic [7:0] addr;
   } iodsc_sw_in_t;

   // Software register port
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } iodsc_bus_t;
endpackage : iodsc_pkg

`timescale 1ns/1ns

// Three-stage pin synchroniser; output moves only when stages two and three agree
module iodsc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // Stage one feeds only stage two, so metastability never reaches a gate
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Per bit filter: accept a level once two stages hold it
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk_i) begin
         if (rst_i) begin
            q_o[i] <= 1'b0;
         end else if (s2_reg[i] == s3_reg[i]) begin
            q_o[i] <= s3_reg[i];
         end
      end
   end
endmodule // iodsc_sync

`default_nettype wire

/* iodsc_top.sv */
// Channel front end for a custom device controller on the byte-wide I/O channel
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module iodsc_top (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Host channel pins
   input wire iodsc_pkg::iodsc_ch_in_t ch_i,
   output logic [7:0] ch_data_o,
   output logic ch_data_oe_o,
   output logic ch_prio_out_o,
   // Switches and power monitor
   input wire iodsc_pkg::iodsc_sw_in_t sw_i,
   // Controller logic side
   input wire logic dev_req_i,
   output logic [7:0] sw_addr_o,
   output logic match_o,
   output logic active_o,
   output logic window_o,
   output logic relay_on_o,
   // Software register port
   input wire iodsc_pkg::iodsc_bus_t bus_i,
   output logic [31:0] rdata_o
);
   import iodsc_pkg::*;

   localparam int SYNC_W = $bits(iodsc_ch_in_t) + $bits(iodsc_sw_in_t);

   iodsc_ch_in_t chs;
   iodsc_sw_in_t sws;
   logic [31:0] ctrl_reg;
   logic [7:0] status_reg;
   logic online_reg;
   logic match_reg;
   logic active_reg;
   logic window_reg;
   logic stat_drv_reg;
   logic addr_drv_reg;
   logic cyc_d_reg;
   logic [3:0] hold_reg;
   logic [7:0] sw_addr_reg;
   logic prio_out_reg;
   logic [7:0] data_reg;
   logic data_oe_reg;
   logic [31:0] rdata_reg;
   logic cyc;
   logic cyc_rise;
   logic online_next;
   logic win_prio;
   logic [31:0] state_word;

   // All channel, switch and power pins cross into the clock domain together
   iodsc_sync #(
      .W(SYNC_W)
   ) u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .d_i({ch_i, sw_i}),
      .q_o({chs, sws})
   );

   // Selection cycle is either an interrupt acknowledge or a service request
   assign cyc = chs.ack | chs.svc;
   assign cyc_rise = cyc & ~cyc_d_reg;
   // Off by switch, by power loss or by software
   assign online_next = ~sws.offline & sws.pwr_ok & ~ctrl_reg[CTRL_FORCE_OFF_BIT];
   // Win when upstream grants priority and this unit wants service
   assign win_prio = online_reg & chs.prio_in & dev_req_i;

   // Software control and status byte
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl_reg <= CTRL_RESET;
         status_reg <= STATUS_RESET;
      end else if (bus_i.wr) begin
         if (bus_i.addr == REG_CTRL) begin
            ctrl_reg <= {31'h0000_0000, bus_i.wdata[CTRL_FORCE_OFF_BIT]};
         end
         if (bus_i.addr == REG_STATUS) begin
            status_reg <= bus_i.wdata[7:0];
         end
      end
   end

   // Guard flip-flop one: on-line state, also drives the isolation relays
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         online_reg <= 1'b0;
      end else begin
         online_reg <= online_next;
      end
   end

   // Switch copy and address match
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sw_addr_reg <= 8'h00;
         match_reg <= 1'b0;
      end else begin
         sw_addr_reg <= sws.addr;
         match_reg <= online_reg && (sws.addr == chs.addr);
      end
   end

   // Priority chain: pass the grant on only when this unit does not take it
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         prio_out_reg <= 1'b0;
         cyc_d_reg <= 1'b0;
      end else begin
         cyc_d_reg <= cyc;
         // Off-line relays bypass the unit so the chain stays intact
         if (!online_reg) begin
            prio_out_reg <= chs.prio_in;
         end else begin
            prio_out_reg <= chs.prio_in & ~dev_req_i & ~active_reg;
         end
      end
   end

   // Guard flip-flop two: active after winning, held for the whole cycle
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         active_reg <= 1'b0;
      end else if (!online_reg || !cyc) begin
         active_reg <= 1'b0;
      end else if (cyc_rise && win_prio) begin
         active_reg <= 1'b1;
      end
   end

   // Guard flip-flop three: address answer during acknowledge or service
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         addr_drv_reg <= 1'b0;
      end else begin
         addr_drv_reg <= active_reg & cyc & online_reg;
      end
   end

   // Guard flip-flop four: transfer window, closed by end of transfer
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         window_reg <= 1'b0;
      end else if (!online_reg || !chs.svc || chs.xfer_end) begin
         window_reg <= 1'b0;
      end else if (active_reg) begin
         window_reg <= 1'b1;
      end
   end

   // Guard flip-flop five: status on the lines for a query to this address
   // A query during a selection cycle is refused to avoid two drivers
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         stat_drv_reg <= 1'b0;
         hold_reg <= 4'h0;
      end else if (!online_reg || cyc) begin
         stat_drv_reg <= 1'b0;
         hold_reg <= 4'h0;
      end else if (chs.query && match_reg && !stat_drv_reg) begin
         stat_drv_reg <= 1'b1;
         hold_reg <= STAT_HOLD_CYC;
      end else if (stat_drv_reg) begin
         if (hold_reg > 4'h1) begin
            hold_reg <= hold_reg - 4'h1;
         end else if (!chs.query) begin
            stat_drv_reg <= 1'b0;
            hold_reg <= 4'h0;
         end
      end
   end

   // Data line driver: address answer has priority over status
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         data_reg <= 8'h00;
         data_oe_reg <= 1'b0;
      end else if (addr_drv_reg) begin
         data_reg <= sw_addr_reg;
         data_oe_reg <= 1'b1;
      end else if (stat_drv_reg) begin
         data_reg <= status_reg;
         data_oe_reg <= 1'b1;
      end else begin
         data_reg <= 8'h00;
         data_oe_reg <= 1'b0;
      end
   end

   // State word seen by software
   always_comb begin
      state_word = 32'h0000_0000;
      state_word[ST_ONLINE_BIT] = online_reg;
      state_word[ST_MATCH_BIT] = match_reg;
      state_word[ST_ACTIVE_BIT] = active_reg;
      state_word[ST_WINDOW_BIT] = window_reg;
      state_word[ST_STATDRV_BIT] = stat_drv_reg;
      state_word[ST_ADDRDRV_BIT] = addr_drv_reg;
      state_word[ST_SWADDR_LSB +: 8] = sw_addr_reg;
   end

   // Read data one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (bus_i.rd) begin
         case (bus_i.addr)
            REG_CTRL: rdata_reg <= ctrl_reg;
            REG_STATUS: rdata_reg <= {24'h00_0000, status_reg};
            REG_STATE: rdata_reg <= state_word;
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   // Outputs come straight from flip-flops
   assign ch_data_o = data_reg;
   assign ch_data_oe_o = data_oe_reg;
   assign ch_prio_out_o = prio_out_reg;
   assign sw_addr_o = sw_addr_reg;
   assign match_o = match_reg;
   assign active_o = active_reg;
   assign window_o = window_reg;
   assign relay_on_o = online_reg;
   assign rdata_o = rdata_reg;

   // Checks on the guard logic
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   a_match_exact: assert property (match_reg |-> $past(online_reg) && $past(sws.addr == chs.addr))
      else $error("match without equal address or while off-line");
   a_offline_quiet: assert property (!online_reg |=> ##1 !data_oe_reg && !active_reg)
      else $error("channel driven while off-line");
   a_power_drop: assert property (!sws.pwr_ok |=> !online_reg)
      else $error("power loss did not take unit off-line");
   a_win_active: assert property (cyc_rise && win_prio |=> active_reg)
      else $error("won priority but not active");
   a_prio_block: assert property (online_reg && dev_req_i |=> !prio_out_reg)
      else $error("grant passed on while requesting");
   a_active_cause: assert property ($rose(active_reg) |-> $past(chs.prio_in && dev_req_i))
      else $error("active without grant and request");
   a_addr_answer: assert property (addr_drv_reg |=> data_oe_reg && data_reg == $past(sw_addr_reg))
      else $error("switch address not driven back");
   a_status_hold: assert property ($rose(stat_drv_reg) && !cyc && online_reg |=> stat_drv_reg ##1 stat_drv_reg)
      else $error("status dropped before least hold");
   a_window_only: assert property (window_reg |-> active_reg || $past(active_reg))
      else $error("window open while not active");
   a_window_close: assert property (chs.xfer_end |=> !window_reg)
      else $error("window stayed open after end of transfer");
   a_one_driver: assert property (!(stat_drv_reg && addr_drv_reg))
      else $error("status and address drivers both on");
   a_match_use: assert property (chs.query && !match_reg && !stat_drv_reg |=> !stat_drv_reg)
      else $error("query for other address answered");

   c_ack_cycle: cover property (cyc_rise && chs.ack && win_prio ##2 data_oe_reg);
   c_service_window: cover property (active_reg && chs.svc ##1 window_reg);
   c_status_query: cover property ($rose(stat_drv_reg) ##2 data_oe_reg);
   c_go_offline: cover property ($fell(online_reg));
   c_prio_bypass: cover property (!online_reg && chs.prio_in ##1 prio_out_reg);

   // Off-line relays hand the grant straight through
   a_prio_bypass: assert property (!online_reg |=> prio_out_reg == $past(chs.prio_in))
      else $error("grant not bypassed while off-line");

   // An idle on-line unit passes the grant on unchanged
   a_prio_pass: assert property (online_reg && !dev_req_i && !active_reg |=> prio_out_reg == $past(chs.prio_in))
      else $error("grant held by idle unit");

   // Active can only follow a cycle in which the unit was on-line
   a_active_online: assert property (active_reg |-> $past(online_reg))
      else $error("active while off-line");

   // Address answer only for a live selection cycle this unit owns
   a_addr_cause: assert property (addr_drv_reg |-> $past(active_reg && cyc && online_reg))
      else $error("address driven without selection");

   // Window needs a service cycle on an on-line unit
   a_window_svc: assert property (window_reg |-> $past(chs.svc) && $past(online_reg))
      else $error("window open outside service");

   // Window opens once the active unit is in service
   a_window_open: assert property (active_reg && chs.svc && online_reg && !chs.xfer_end |=> window_reg)
      else $error("window not opened in service");

   // Selection cycles and off-line state refuse the status driver
   a_stat_refuse: assert property (cyc || !online_reg |=> !stat_drv_reg)
      else $error("status driven during selection or off-line");

   // Status byte reaches the lines one cycle after the driver turns on
   a_stat_data: assert property (stat_drv_reg && !addr_drv_reg |=> data_oe_reg && data_reg == $past(status_reg))
      else $error("status byte not on data lines");

   // Match is dropped as soon as the relays open
   a_off_nomatch: assert property (!online_reg |=> !match_reg)
      else $error("match reported while off-line");
endmodule // iodsc_top

`default_nettype wire

/* iodsc_host.sv */
// Host processor and I/O system model that drives the channel pins of the unit
`timescale 1ns/1ns
`default_nettype none

module iodsc_host (
   // Clock
   input wire logic mclk_i,
   // Channel pins toward the unit
   output var iodsc_pkg::iodsc_ch_in_t ch_o,
   input wire logic [7:0] ch_data_i,
   input wire logic ch_data_oe_i,
   // Last byte the unit placed on the data lines
   output var logic [7:0] seen_o
);
   import iodsc_pkg::*;

   // Idle channel: no stimulus, address lines at zero
   initial begin
      ch_o = '0;
      seen_o = 8'h00;
   end

   // Present an address on the channel address lines
   task automatic put_addr(input logic [7:0] a);
      @(posedge mclk_i);
      ch_o.addr <= a;
   endtask

   // Stimuli for query, acknowledge, service, priority and end of transfer
   task automatic pins(input logic q, input logic ak, input logic sv, input logic pr,
                       input logic xe);
      @(posedge mclk_i);
      ch_o.query <= q;
      ch_o.ack <= ak;
      ch_o.svc <= sv;
      ch_o.prio_in <= pr;
      ch_o.xfer_end <= xe;
   endtask

   // Capture the data lines only while the unit drives them; otherwise they float
   always @(posedge mclk_i) begin
      if (ch_data_oe_i === 1'b1) begin
         seen_o <= ch_data_i;
      end
   end
endmodule // iodsc_host

`default_nettype wire

/* io_channel_device_subcontroller_bench.sv */
// Self-checking testbench for the I/O channel device subcontroller
`timescale 1ns/1ns
`default_nettype none

module io_channel_device_subcontroller_bench;
   import iodsc_pkg::*;

   typedef struct packed {
      logic [7:0] sw;
      logic [7:0] ad;
      logic m;
   } iodsc_row_t;

   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   iodsc_ch_in_t ch_i;
   iodsc_sw_in_t sw_i = '{offline: 1'b0, pwr_ok: 1'b1, addr: 8'h00};
   iodsc_bus_t bus_i = '0;
   logic dev_req_i = 1'b0;
   logic [7:0] ch_data_o, sw_addr_o, seen;
   logic ch_data_oe_o, ch_prio_out_o, match_o, active_o, window_o, relay_on_o;
   logic [31:0] rdata_o, rv;
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;
   int c;
   iodsc_row_t rows [5] = '{'{8'h5A, 8'h5A, 1'b1}, '{8'h5A, 8'h5B, 1'b0},
      '{8'h00, 8'h00, 1'b1}, '{8'hFF, 8'h7F, 1'b0}, '{8'hA5, 8'h25, 1'b0}};

   // 20 MHz clock
   always #25 mclk_i = ~mclk_i;

   iodsc_top u_iodsc_top (.mclk_i(mclk_i), .rst_i(rst_i), .ch_i(ch_i),
      .ch_data_o(ch_data_o), .ch_data_oe_o(ch_data_oe_o), .ch_prio_out_o(ch_prio_out_o),
      .sw_i(sw_i), .dev_req_i(dev_req_i), .sw_addr_o(sw_addr_o), .match_o(match_o),
      .active_o(active_o), .window_o(window_o), .relay_on_o(relay_on_o), .bus_i(bus_i),
      .rdata_o(rdata_o));

   iodsc_host u_iodsc_host (.mclk_i(mclk_i), .ch_o(ch_i), .ch_data_i(ch_data_o),
      .ch_data_oe_i(ch_data_oe_o), .seen_o(seen));

   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
      n_checks++;
      if (seen_v !== exp_v) begin
         miscompares++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask

   // Pins pass four synchroniser flops, so let them settle before looking
   task automatic settle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      bus_i.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      bus_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i);
      bus_i.rd <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   // Count cycles the unit drives the data lines within a window
   task automatic count_oe(input int n, output int k);
      k = 0;
      repeat (n) begin
         @(posedge mclk_i);
         #1;
         if (ch_data_oe_o === 1'b1) k++;
      end
   endtask

   // Hang guard, well above the expected run of a few hundred cycles
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      settle(19);
      check({relay_on_o, active_o, ch_data_oe_o, window_o}, 4'h0);
      // Release on the twentieth edge so reset spans a full 20 cycles
      @(posedge mclk_i);
      rst_i <= 1'b0;
      // Table of switch settings against channel addresses
      foreach (rows[i]) begin
         sw_i.addr <= rows[i].sw;
         u_iodsc_host.put_addr(rows[i].ad);
         settle(8);
         check(match_o, rows[i].m);
         check(sw_addr_o, rows[i].sw);
      end
      sw_i.addr <= 8'h3C;
      u_iodsc_host.put_addr(8'h3C);
      settle(8);
      wr_reg(REG_STATUS, 32'h0000_00A5);
      rd_reg(REG_STATUS, rv);
      check(rv, 32'h0000_00A5);
      rd_reg(4'hC, rv);
      check(rv, 32'h0000_0000);
      rd_reg(REG_CTRL, rv);
      check(rv, CTRL_RESET);
      rd_reg(REG_STATE, rv);
      check(rv, 32'h0000_3C03);
      // Short query: status must stay up for its least hold time
      u_iodsc_host.pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      settle(4);
      u_iodsc_host.pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      count_oe(12, c);
      check(c >= int'(STAT_HOLD_CYC), 1'b1);
      check(seen, 8'hA5);
      // Query for another address is ignored
      u_iodsc_host.put_addr(8'h3D);
      u_iodsc_host.pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      count_oe(10, c);
      check(c, 0);
      u_iodsc_host.pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      u_iodsc_host.put_addr(8'h3C);
      // Interrupt acknowledge won with priority
      dev_req_i <= 1'b1;
      u_iodsc_host.pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      settle(8);
      check({active_o, ch_data_oe_o, ch_prio_out_o, window_o}, 4'hC);
      check(seen, 8'h3C);
      u_iodsc_host.pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      settle(8);
      check({active_o, ch_data_oe_o}, 2'b00);
      // No upstream grant: the unit stays inactive
      u_iodsc_host.pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      settle(8);
      check({active_o, ch_prio_out_o}, 2'b00);
      u_iodsc_host.pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      dev_req_i <= 1'b0;
      settle(8);
      check(ch_prio_out_o, 1'b1);
      // Service cycle opens the window, end of transfer closes it
      dev_req_i <= 1'b1;
      u_iodsc_host.pins(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      settle(8);
      check({active_o, window_o}, 2'b11);
      u_iodsc_host.pins(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      settle(8);
      check(window_o, 1'b0);
      u_iodsc_host.pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      dev_req_i <= 1'b0;
      settle(8);
      // Off-line switch, power loss and software force each isolate the unit
      sw_i.offline <= 1'b1;
      u_iodsc_host.pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      count_oe(10, c);
      check({relay_on_o, match_o, ch_prio_out_o}, 3'b001);
      check(c, 0);
      u_iodsc_host.pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      sw_i.offline <= 1'b0;
      sw_i.pwr_ok <= 1'b0;
      settle(8);
      check(relay_on_o, 1'b0);
      sw_i.pwr_ok <= 1'b1;
      settle(8);
      check(relay_on_o, 1'b1);
      wr_reg(REG_CTRL, 32'h0000_0001);
      settle(4);
      check(relay_on_o, 1'b0);
      stop_test();
   end
endmodule // io_channel_device_subcontroller_bench

`default_nettype wire
